/* pkg/sdpwm_pkg.sv */
// Purpose: Shared constants for the subdivided PWM output block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package sdpwm_pkg;
	localparam logic [11:0] DUTY_OFFS = 12'h000;
	localparam logic [11:0] CTRL_OFFS = 12'h004;
	localparam logic [11:0] PORT_OFFS = 12'h008;
	localparam logic [11:0] STAT_OFFS = 12'h00C;
	localparam int CTRL_MODE_BIT = 5;
	localparam int CTRL_FUNC_BIT = 3;
	localparam int PORT_DATA_BIT = 0;
	localparam int PORT_DIR_BIT = 1;
	localparam int PORT_PULL_BIT = 2;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] PORT_RST = 3'h2;
	localparam int PERIOD_CLKS = 256;
	localparam int SUB62_CLKS = 64;
	localparam int SUB71_CLKS = 128;
	typedef enum logic {SDPWM_MODE_62, SDPWM_MODE_71} sdpwm_mode_e;
	typedef struct packed {
		logic [7:0] duty;
		logic [7:0] ctrl;
		logic [2:0] port;
		logic [7:0] act_duty;
		sdpwm_mode_e act_mode;
		logic [7:0] cnt;
		logic wave;
		logic pin_in_s1;
		logic pin_in_s2;
		logic [31:0] prdata;
	} sdpwm_state_s;
endpackage : sdpwm_pkg

/* rtl/sdpwm_top.sv */
// Purpose: Single-channel 8-bit PWM with 6+2 / 7+1 sub-cycle split, pin shared with a GPIO bit.
// Assumes: pclk is the system clock; software programs registers over APB.
// Notes: Mode and duty are latched at each full-period boundary so a period is never torn.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module sdpwm_top
	import sdpwm_pkg::*;
(
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shared pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pin_pull_en
);
	sdpwm_state_s s_q, s_d;
	logic wr, rd, hit;
	logic [6:0] sub_pos;
	logic [1:0] sub_idx;
	logic [6:0] base;
	logic [1:0] extra;
	logic [7:0] high_len;
	logic func_on, dir_in;

	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign hit = (paddr == DUTY_OFFS) || (paddr == CTRL_OFFS) || (paddr == PORT_OFFS) || (paddr == STAT_OFFS);
	// Unmapped addresses answer with an error so stray software is caught.
	assign pslverr = psel && penable && !hit;
	assign prdata = s_q.prdata;

	assign func_on = s_q.ctrl[CTRL_FUNC_BIT];
	assign dir_in = s_q.port[PORT_DIR_BIT];

	always_comb begin
		s_d = s_q;
		sub_pos = 7'h00;
		sub_idx = 2'h0;
		base = 7'h00;
		extra = 2'h0;
		high_len = 8'h00;
		if (wr && paddr == DUTY_OFFS) begin
			s_d.duty = pwdata[7:0];
		end
		if (wr && paddr == CTRL_OFFS) begin
			s_d.ctrl = pwdata[7:0];
		end
		if (wr && paddr == PORT_OFFS) begin
			s_d.port = pwdata[2:0];
		end
		if (rd) begin
			unique case (paddr)
				DUTY_OFFS: s_d.prdata = {24'h000000, s_q.duty};
				CTRL_OFFS: s_d.prdata = {24'h000000, s_q.ctrl};
				PORT_OFFS: s_d.prdata = {29'h00000000, s_q.port};
				STAT_OFFS: s_d.prdata = {22'h000000, s_q.pin_in_s2, s_q.wave, s_q.cnt};
				default: s_d.prdata = 32'h00000000;
			endcase
		end
		// Free-running period counter on the system clock; wraps every 256 clocks.
		s_d.cnt = s_q.cnt + 8'h01;
		if (s_q.act_mode == SDPWM_MODE_71) begin
			sub_pos = s_q.cnt[6:0];
			sub_idx = {1'b0, s_q.cnt[7]};
			base = s_q.act_duty[7:1];
			extra = {1'b0, s_q.act_duty[0]};
		end else begin
			sub_pos = {1'b0, s_q.cnt[5:0]};
			sub_idx = s_q.cnt[7:6];
			base = {1'b0, s_q.act_duty[7:2]};
			extra = s_q.act_duty[1:0];
		end
		high_len = {1'b0, base} + ((sub_idx < extra) ? 8'h01 : 8'h00);
		s_d.wave = ({1'b0, sub_pos} < high_len);
		// Latch duty and mode on the last clock so the next period starts cleanly.
		if (s_q.cnt == 8'(PERIOD_CLKS - 1)) begin
			s_d.act_duty = s_d.duty;
			s_d.act_mode = s_d.ctrl[CTRL_MODE_BIT] ? SDPWM_MODE_71 : SDPWM_MODE_62;
		end
		s_d.pin_in_s1 = pin_in;
		s_d.pin_in_s2 = s_q.pin_in_s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '{duty: DUTY_RST, ctrl: CTRL_RST, port: PORT_RST, act_duty: DUTY_RST,
				act_mode: SDPWM_MODE_62, cnt: 8'h00, wave: 1'b0, pin_in_s1: 1'b0,
				pin_in_s2: 1'b0, prdata: 32'h00000000};
		end else begin
			s_q <= s_d;
		end
	end

	// Pin mux: as a plain GPIO the data bit drives the pin when direction is output.
	assign pin_oe = !dir_in;
	assign pin_out = func_on ? (s_q.port[PORT_DATA_BIT] & s_q.wave) : s_q.port[PORT_DATA_BIT];
	assign pin_pull_en = dir_in & s_q.port[PORT_PULL_BIT];

	chk_gate_low: assert property (@(posedge pclk) disable iff (!presetn)
		(func_on && !s_q.port[PORT_DATA_BIT]) |-> !pin_out) else $error("pin not held low when gated off");
	chk_gate_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(func_on && s_q.port[PORT_DATA_BIT]) |-> (pin_out == s_q.wave)) else $error("waveform not passed");
	chk_input_dir: assert property (@(posedge pclk) disable iff (!presetn)
		dir_in |-> !pin_oe) else $error("pin driven while set as input");
	chk_period_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt == 8'hFF) |=> (s_q.cnt == 8'h00)) else $error("period not 256 clocks");
	chk_start_high: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt == 8'h00 && s_q.act_duty >= 8'h04) |=> s_q.wave) else $error("sub-cycle not starting high");
	chk_zero_duty: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_duty == 8'h00 && $past(s_q.act_duty) == 8'h00) |-> !s_q.wave) else $error("wave high at zero duty");
	chk_duty_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt != 8'h00) |-> $stable(s_q.act_duty)) else $error("duty changed mid period");
	chk_mode_sel: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt == 8'hFF) |=> (s_q.act_mode == (s_q.ctrl[CTRL_MODE_BIT] ? SDPWM_MODE_71 : SDPWM_MODE_62)))
		else $error("mode not taken at boundary");
	chk_extra_71: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_71 && s_q.act_duty == 8'h01 && s_q.cnt == 8'h00) |=> s_q.wave ##1 !s_q.wave)
		else $error("seven-plus-one extra count wrong");

	// Reference view used only by the checks below.
	// It works from the period position by shifts and masks instead of the sub-cycle slices above.
	// A slip in either slicing then shows up as a mismatch rather than agreeing with itself.
	localparam int SPLIT62 = $clog2(PERIOD_CLKS / SUB62_CLKS);
	localparam int SPLIT71 = $clog2(PERIOD_CLKS / SUB71_CLKS);
	localparam int POS62 = $clog2(SUB62_CLKS);
	localparam int POS71 = $clog2(SUB71_CLKS);
	localparam logic [8:0] ONE9 = 9'h001;

	logic [8:0] ref_len;
	logic [8:0] ref_div;
	logic [8:0] ref_pos;
	logic [8:0] ref_idx;
	logic [8:0] ref_base;
	logic [8:0] ref_extra;
	logic [8:0] ref_high;
	logic ref_wave;

	always_comb begin
		ref_len = 9'(SUB62_CLKS);
		ref_div = 9'(PERIOD_CLKS / SUB62_CLKS);
		ref_idx = 9'({1'b0, s_q.cnt} >> POS62);
		ref_base = 9'({1'b0, s_q.act_duty} >> SPLIT62);
		if (s_q.act_mode == SDPWM_MODE_71) begin
			ref_len = 9'(SUB71_CLKS);
			ref_div = 9'(PERIOD_CLKS / SUB71_CLKS);
			ref_idx = 9'({1'b0, s_q.cnt} >> POS71);
			ref_base = 9'({1'b0, s_q.act_duty} >> SPLIT71);
		end
		ref_pos = {1'b0, s_q.cnt} & (ref_len - ONE9);
		ref_extra = {1'b0, s_q.act_duty} & (ref_div - ONE9);
		ref_high = ref_base + ((ref_idx < ref_extra) ? ONE9 : 9'h000);
		ref_wave = (ref_pos < ref_high);
	end

	// Register bus checks: zero wait, error only on unmapped offsets, writes land at the access edge.
	chk_ready_const: assert property (@(posedge pclk) disable iff (!presetn)
		pready)
		else $error("ready dropped");

	chk_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && hit) |-> !pslverr)
		else $error("error on mapped offset");

	chk_slverr_miss: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !hit) |-> pslverr)
		else $error("no error on unmapped offset");

	chk_duty_write: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr == DUTY_OFFS) |=> (s_q.duty == $past(pwdata[7:0])))
		else $error("duty write lost");

	chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr == CTRL_OFFS) |=> (s_q.ctrl == $past(pwdata[7:0])))
		else $error("control write lost");

	chk_port_write: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && paddr == PORT_OFFS) |=> (s_q.port == $past(pwdata[2:0])))
		else $error("port write lost");

	chk_miss_nowrite: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && !hit) |=> ($stable(s_q.duty) && $stable(s_q.ctrl) && $stable(s_q.port)))
		else $error("unmapped write changed a register");

	chk_read_duty: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == DUTY_OFFS) |=> (prdata == {24'h000000, $past(s_q.duty)}))
		else $error("duty read wrong");

	chk_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && paddr == CTRL_OFFS) |=> (prdata == {24'h000000, $past(s_q.ctrl)}))
		else $error("control read wrong");

	// Period counter and boundary checks.
	chk_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (s_q.cnt == 8'($past(s_q.cnt) + 8'h01)))
		else $error("counter skipped a clock");

	chk_mode_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt != 8'h00) |-> $stable(s_q.act_mode))
		else $error("mode changed mid period");

	chk_duty_take: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.cnt == 8'hFF) |=> (s_q.act_duty == s_q.duty))
		else $error("duty not taken at boundary");

	// Slicing checks against the reference view.
	chk_pos_62: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_62) |-> ({2'b00, sub_pos} == ref_pos))
		else $error("six-plus-two position wrong");

	chk_pos_71: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_71) |-> ({2'b00, sub_pos} == ref_pos))
		else $error("seven-plus-one position wrong");

	chk_idx_sub: assert property (@(posedge pclk) disable iff (!presetn)
		({7'h00, sub_idx} == ref_idx))
		else $error("sub-cycle index wrong");

	chk_base_62: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_62) |-> ({2'b00, base} == ref_base))
		else $error("six-plus-two base wrong");

	chk_base_71: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_71) |-> ({2'b00, base} == ref_base))
		else $error("seven-plus-one base wrong");

	chk_extra_62: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_62) |-> ({7'h00, extra} == ref_extra))
		else $error("six-plus-two extra wrong");

	chk_extra_val71: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.act_mode == SDPWM_MODE_71) |-> ({7'h00, extra} == ref_extra))
		else $error("seven-plus-one extra wrong");

	chk_ref_wave: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (s_q.wave == $past(ref_wave)))
		else $error("waveform differs from reference");

	chk_sub_start: assert property (@(posedge pclk) disable iff (!presetn)
		(ref_pos == 9'h000 && ref_high != 9'h000) |=> s_q.wave)
		else $error("non-empty sub-cycle not starting high");

	chk_high_range: assert property (@(posedge pclk) disable iff (!presetn)
		({1'b0, high_len} <= ref_len))
		else $error("high time longer than sub-cycle");

	// Pin mux checks.
	chk_func_off: assert property (@(posedge pclk) disable iff (!presetn)
		!func_on |-> (pin_out == s_q.port[PORT_DATA_BIT]))
		else $error("plain output not following data bit");

	chk_oe_output: assert property (@(posedge pclk) disable iff (!presetn)
		!dir_in |-> (pin_oe && !pin_pull_en))
		else $error("output pin not driven or pulled");

	chk_pull_input: assert property (@(posedge pclk) disable iff (!presetn)
		dir_in |-> (pin_pull_en == s_q.port[PORT_PULL_BIT]))
		else $error("pull-high not following its bit");

	chk_sync_pin: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (s_q.pin_in_s2 == $past(s_q.pin_in_s1)))
		else $error("pin synchroniser skipped a stage");

	cov_mode_71: cover property (@(posedge pclk) disable iff (!presetn) s_q.act_mode == SDPWM_MODE_71 && s_q.wave);
	cov_mode_62: cover property (@(posedge pclk) disable iff (!presetn) s_q.act_mode == SDPWM_MODE_62 && s_q.wave);
	cov_pin_on: cover property (@(posedge pclk) disable iff (!presetn) func_on && pin_oe && pin_out);
	cov_extra_62: cover property (@(posedge pclk) disable iff (!presetn)
		s_q.act_mode == SDPWM_MODE_62 && s_q.act_duty[1:0] == 2'h3 && s_q.wave);
	cov_gate_off: cover property (@(posedge pclk) disable iff (!presetn)
		func_on && !s_q.port[PORT_DATA_BIT] && s_q.wave);
endmodule : sdpwm_top

/* tb/sdpwm_load.sv */
// Purpose: External load hanging on the shared pin.
// Assumes: Pull-high acts only while the pin is an input.
// Notes: A floating pin toggles, so stale levels never pass for data.
`timescale 1ns/1ps
module sdpwm_load (
	// Pin side
	input wire logic pclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pin_pull_en,
	output logic pin_level
);
	logic last_q = 1'b0;
	always @(posedge pclk) last_q <= pin_level;
	assign pin_level = pin_oe ? pin_out : (pin_pull_en ? 1'b1 : ~last_q);
endmodule : sdpwm_load

/* tb/test_subdivided_pwm_output.sv */
// Purpose: Self-checking bench for the subdivided PWM output.
// Assumes: Zero-wait APB slave; waveform seen on the loaded pin.
// Notes: Windows are aligned to a rising edge, so sub-cycle order is only seen as a count.
`timescale 1ns/1ps
module test_subdivided_pwm_output;
	import sdpwm_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pin_out, pin_oe, pin_pull_en, pin_level, err_q;
	int errors = 0, num_checks = 0, cyc = 0, hi, big;
	sdpwm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en));
	sdpwm_load u_load (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_en(pin_pull_en),
		.pin_level(pin_level));
	initial forever #4 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	task automatic count(input int len);
		hi = 0;
		for (int k = 0; k < len; k++) begin
			hi += pin_level;
			@(posedge pclk);
			#1;
		end
	endtask : count
	task automatic measure(input int n, input int len, input int base, input int extra);
		logic b;
		big = 0;
		repeat (300) @(posedge pclk);
		do begin
			b = pin_level;
			@(posedge pclk);
			#1;
		end while (!(b === 1'b0 && pin_level === 1'b1));
		for (int w = 0; w < n; w++) begin
			count(len);
			if (hi == base + 1) big++;
			else chk(hi, base);
		end
		chk(big, extra);
	endtask : measure
	task automatic t_regs;
		apb(1'b0, PORT_OFFS, 32'h0);
		chk(rd, {29'h0, PORT_RST});
		chk(pin_oe, 1'b0);
		apb(1'b0, 12'h010, 32'h0);
		chk(err_q, 1'b1);
	endtask : t_regs
	task automatic t_modes;
		apb(1'b1, DUTY_OFFS, 32'h0000000D);
		apb(1'b1, CTRL_OFFS, 32'h00000008);
		apb(1'b1, PORT_OFFS, 32'h00000001);
		measure(4, SUB62_CLKS, 3, 1);
		apb(1'b1, DUTY_OFFS, 32'h000000FB);
		measure(4, SUB62_CLKS, 62, 3);
		apb(1'b1, CTRL_OFFS, 32'h00000028);
		measure(2, SUB71_CLKS, 125, 1);
	endtask : t_modes
	task automatic t_gate;
		apb(1'b1, PORT_OFFS, 32'h0);
		count(PERIOD_CLKS);
		chk(hi, 0);
		apb(1'b1, CTRL_OFFS, 32'h0);
		apb(1'b1, PORT_OFFS, 32'h00000001);
		count(PERIOD_CLKS);
		chk(hi, PERIOD_CLKS);
		apb(1'b1, CTRL_OFFS, 32'h00000008);
		apb(1'b1, PORT_OFFS, 32'h00000006);
		chk(pin_pull_en, 1'b1);
		repeat (3) @(posedge pclk);
		apb(1'b0, STAT_OFFS, 32'h0);
		chk(rd[9], 1'b1);
	endtask : t_gate
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_modes();
		t_gate();
		tally_and_finish();
	end
endmodule : test_subdivided_pwm_output
